/* File: core/dopwm_core.sv */
// dual output pulse-width modulator with apb register access
// assumes clock-source pins toggle slower than half of sys_clk_i
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module dopwm_core
   import dopwm_pkg::*;
#(
   parameter int VAL_W = 16
)
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic xtal_clk_i,
   input wire logic pll_clk_i,
   input wire logic external_count_clock_i,
   output logic output_a_o,
   output logic output_a_oe_n_o,
   output logic output_b_o,
   output logic output_b_oe_n_o
);
   if (VAL_W != 16)
   begin : g_bad_width
      $error("value registers must be 16 bits");
   end

   logic [7:0] ctrl_reg;
   logic [7:0] hid_a_reg;
   logic [7:0] hid_b_reg;
   logic [15:0] pend_a_reg;
   logic [15:0] pend_b_reg;
   logic upd_reg;
   logic [15:0] val_a_reg;
   logic [15:0] val_b_reg;
   logic [15:0] cnt_reg;
   logic [7:0] cnt_b_reg;
   logic [15:0] acc_a_reg;
   logic [15:0] acc_b_reg;
   logic sd_a_reg;
   logic sd_b_reg;
   logic [15:0] gap_reg;
   logic [14:0] half_reg;
   logic [14:0] rz_a_reg;
   logic [14:0] rz_b_reg;
   logic tw_b_reg;
   logic out_a_reg;
   logic out_b_reg;
   logic [31:0] prdata_reg;
   logic [SYNC_PINS-1:0] pins;
   logic [SYNC_PINS-1:0] rises;
   logic [2:0] mode;
   logic tick;
   logic wr;
   logic ctrl_wr;
   logic is8;
   logic cyc_end;
   logic wrap;
   logic [16:0] sum_a;
   logic [16:0] sum_b;
   logic [15:0] per_m1;
   logic [14:0] rz_load;
   logic out_a_next;
   logic out_b_next;

   // decode of the word index into a register select
   function automatic logic [2:0] dopwm_sel(input logic [ADDR_W-1:0] a);
      logic [7:0] idx;
      idx = a[ADDR_W-1:2];
      if (idx == CTRL_IDX) return 3'h1;
      if (idx == VA_LO_IDX) return 3'h2;
      if (idx == VA_HI_IDX) return 3'h3;
      if (idx == VB_LO_IDX) return 3'h4;
      if (idx == VB_HI_IDX) return 3'h5;
      if (idx == STAT_IDX) return 3'h6;
      return 3'h0;
   endfunction : dopwm_sel

   // ---- clock source pins and prescaler
   assign pins = {pll_clk_i, external_count_clock_i, xtal_clk_i};

   for (genvar i = 0; i < SYNC_PINS; i++)
   begin : g_sync
      dopwm_pin_sync u_sync
      (
         .sys_clk_i(sys_clk_i),
         .rstn_i(rstn_i),
         .pin_i(pins[i]),
         .rise_o(rises[i])
      );
   end

   dopwm_prescale u_pre
   (
      .sys_clk_i(sys_clk_i),
      .rstn_i(rstn_i),
      .clear_i(ctrl_wr),
      .src_i(ctrl_reg[SRC_LSB +: 2]),
      .pre_i(ctrl_reg[PRE_LSB +: 2]),
      .xtal_rise_i(rises[0]),
      .pin_rise_i(rises[1]),
      .pll_rise_i(rises[2]),
      .tick_o(tick)
   );

   // ---- apb slave, zero wait states
   assign pready_o = psel_i & penable_i;
   assign pslverr_o = psel_i & penable_i & (dopwm_sel(paddr_i) == 3'h0);
   assign wr = psel_i & penable_i & pwrite_i;
   assign ctrl_wr = wr & (dopwm_sel(paddr_i) == 3'h1);
   assign prdata_o = prdata_reg;

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         prdata_reg <= 32'h0000_0000;
      else if (psel_i & ~penable_i & ~pwrite_i)
      begin
         unique case (dopwm_sel(paddr_i))
            3'h1: prdata_reg <= {24'h00_0000, 1'b0, ctrl_reg[6:0]};
            3'h2: prdata_reg <= {24'h00_0000, val_a_reg[7:0]};
            3'h3: prdata_reg <= {24'h00_0000, val_a_reg[15:8]};
            3'h4: prdata_reg <= {24'h00_0000, val_b_reg[7:0]};
            3'h5: prdata_reg <= {24'h00_0000, val_b_reg[15:8]};
            3'h6: prdata_reg <= {13'h0000, upd_reg, output_b_o, output_a_o,
                                 cnt_reg};
            default: prdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         ctrl_reg <= CTRL_RST; // [RL22]
      else if (ctrl_wr)
         ctrl_reg <= {1'b0, pwdata_i[6:0]}; // [RL1]
   end

   assign mode = ctrl_reg[MODE_LSB +: 3]; // [RL1]
   assign is8 = (mode == MODE_TWIN8) | (mode == MODE_DUAL8);

   // ---- value registers: hidden low byte, pending word, live word
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         hid_a_reg <= 8'h00;
         hid_b_reg <= 8'h00;
      end
      else if (wr)
      begin
         if (dopwm_sel(paddr_i) == 3'h2)
            hid_a_reg <= pwdata_i[7:0]; // [RL5]
         if (dopwm_sel(paddr_i) == 3'h4)
            hid_b_reg <= pwdata_i[7:0]; // [RL5]
      end
   end

   // 8-bit modes take each byte on its own; 16-bit modes pair bytes
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         pend_a_reg <= VAL_RST;
         pend_b_reg <= VAL_RST;
      end
      else if (wr)
      begin
         unique case (dopwm_sel(paddr_i))
            3'h2: if (is8) pend_a_reg[7:0] <= pwdata_i[7:0];
            3'h3: pend_a_reg <= {pwdata_i[7:0],
                                 is8 ? pend_a_reg[7:0] : hid_a_reg}; // [RL5]
            3'h4: if (is8) pend_b_reg[7:0] <= pwdata_i[7:0];
            3'h5: pend_b_reg <= {pwdata_i[7:0],
                                 is8 ? pend_b_reg[7:0] : hid_b_reg}; // [RL5]
            default: ;
         endcase
      end
   end

   // a new value waits for the end of the running cycle; a write
   // landing on the same cycle as the transfer stays pending
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         upd_reg <= 1'b0;
      else if (wr & ((dopwm_sel(paddr_i) == 3'h3) |
                     (dopwm_sel(paddr_i) == 3'h5) |
                     (is8 & ((dopwm_sel(paddr_i) == 3'h2) |
                             (dopwm_sel(paddr_i) == 3'h4)))))
         upd_reg <= 1'b1;
      else if (wrap | (mode == MODE_OFF) | (mode == 3'h7))
         upd_reg <= 1'b0;
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         val_a_reg <= VAL_RST;
         val_b_reg <= VAL_RST;
      end
      else if (upd_reg & (wrap | (mode == MODE_OFF) | (mode == 3'h7)))
      begin
         val_a_reg <= pend_a_reg; // [RL6]
         val_b_reg <= pend_b_reg; // [RL6]
      end
   end

   // ---- counter
   assign per_m1 = val_b_reg - 16'h0001; // [RL8] zero means 65536

   always_comb
   begin
      unique case (mode)
         MODE_SINGLE: cyc_end = (cnt_reg == per_m1); // [RL8]
         MODE_TWIN8: cyc_end = (cnt_reg[7:0] == val_b_reg[7:0]); // [RL10]
         MODE_TWIN16: cyc_end = (cnt_reg == 16'hffff); // [RL13]
         MODE_DUAL8: cyc_end = (cnt_reg[7:0] == val_b_reg[7:0]); // [RL18]
         MODE_NRZ, MODE_RZ: cyc_end = 1'b1;
         default: cyc_end = 1'b0;
      endcase
   end

   assign wrap = tick & cyc_end;

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cnt_reg <= 16'h0000;
      else if (ctrl_wr | (mode == MODE_OFF) | (mode == 3'h7))
         cnt_reg <= 16'h0000; // [RL4] [RL20]
      else if (tick)
         cnt_reg <= cyc_end ? 16'h0000 : cnt_reg + 16'h0001;
   end

   // output b of dual 8-bit mode runs its own period
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         cnt_b_reg <= 8'h00;
      else if (ctrl_wr | (mode != MODE_DUAL8))
         cnt_b_reg <= 8'h00; // [RL4]
      else if (tick)
         cnt_b_reg <= (cnt_b_reg == val_b_reg[15:8]) ? 8'h00 :
                      cnt_b_reg + 8'h01; // [RL18]
   end

   // ---- sigma-delta accumulators; the carry is the output bit
   assign sum_a = {1'b0, acc_a_reg} + {1'b0, val_a_reg};
   assign sum_b = {1'b0, acc_b_reg} + {1'b0, val_b_reg};

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         acc_a_reg <= 16'h0000;
         acc_b_reg <= 16'h0000;
         sd_a_reg <= 1'b0;
         sd_b_reg <= 1'b0;
      end
      else if (ctrl_wr | ((mode != MODE_NRZ) & (mode != MODE_RZ)))
      begin
         acc_a_reg <= 16'h0000;
         acc_b_reg <= 16'h0000;
         sd_a_reg <= 1'b0;
         sd_b_reg <= 1'b0;
      end
      else if (tick)
      begin
         acc_a_reg <= sum_a[15:0]; // [RL17]
         acc_b_reg <= sum_b[15:0]; // [RL17]
         sd_a_reg <= sum_a[16];
         sd_b_reg <= sum_b[16];
      end
   end

   // ---- return-to-zero timing: half of the measured tick interval
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         gap_reg <= 16'h0000;
         half_reg <= 15'h0001;
      end
      else if (tick)
      begin
         gap_reg <= 16'h0001;
         half_reg <= (gap_reg[15:1] == 15'h0000) ? 15'h0001 : gap_reg[15:1];
      end
      else if (gap_reg != 16'hffff)
         gap_reg <= gap_reg + 16'h0001;
   end

   assign rz_load = half_reg;

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rz_a_reg <= 15'h0000;
         rz_b_reg <= 15'h0000;
      end
      else if (mode != MODE_RZ)
      begin
         rz_a_reg <= 15'h0000;
         rz_b_reg <= 15'h0000;
      end
      else if (tick)
      begin
         rz_a_reg <= sum_a[16] ? rz_load : 15'h0000; // [RL19]
         rz_b_reg <= sum_b[16] ? rz_load : 15'h0000; // [RL19]
      end
      else
      begin
         if (rz_a_reg != 15'h0000)
            rz_a_reg <= rz_a_reg - 15'h0001;
         if (rz_b_reg != 15'h0000)
            rz_b_reg <= rz_b_reg - 15'h0001;
      end
   end

   // ---- twin 8-bit output b: set and clear points
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         tw_b_reg <= 1'b0;
      else if (mode != MODE_TWIN8)
         tw_b_reg <= 1'b0;
      else if (cnt_reg[7:0] == val_b_reg[15:8])
         tw_b_reg <= 1'b1; // [RL12]
      else if (cnt_reg[7:0] == val_a_reg[15:8])
         tw_b_reg <= 1'b0; // [RL12]
   end

   // ---- output selection
   always_comb
   begin
      unique case (mode)
         MODE_SINGLE:
         begin
            out_a_next = cnt_reg < val_a_reg; // [RL9] [RL21]
            out_b_next = 1'b0;
         end
         MODE_TWIN8:
         begin
            out_a_next = cnt_reg[7:0] < val_a_reg[7:0]; // [RL11]
            out_b_next = tw_b_reg;
         end
         MODE_TWIN16:
         begin
            out_a_next = cnt_reg < val_a_reg; // [RL14] [RL16]
            out_b_next = cnt_reg < val_b_reg; // [RL15] [RL16]
         end
         MODE_NRZ:
         begin
            out_a_next = sd_a_reg; // [RL17]
            out_b_next = sd_b_reg;
         end
         MODE_DUAL8:
         begin
            out_a_next = cnt_reg[7:0] < val_a_reg[7:0]; // [RL18]
            out_b_next = cnt_b_reg < val_a_reg[15:8]; // [RL18]
         end
         MODE_RZ:
         begin
            out_a_next = rz_a_reg != 15'h0000; // [RL19]
            out_b_next = rz_b_reg != 15'h0000;
         end
         default:
         begin
            out_a_next = 1'b0;
            out_b_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         out_a_reg <= 1'b0;
         out_b_reg <= 1'b0;
      end
      else
      begin
         out_a_reg <= out_a_next;
         out_b_reg <= out_b_next;
      end
   end

   assign output_a_o = out_a_reg;
   assign output_b_o = out_b_reg;
   // pins belong to the port logic unless the mode drives them
   assign output_a_oe_n_o = (mode == MODE_OFF) | (mode == 3'h7); // [RL7]
   assign output_b_oe_n_o = (mode == MODE_OFF) | (mode == 3'h7) |
                            (mode == MODE_SINGLE); // [RL7] [RL20] [RL21]

   // ---- checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rstn_i);

   sequence ctrl_write_s;
      ctrl_wr;
   endsequence

   sequence counter_cleared_s;
      cnt_reg == 16'h0000;
   endsequence

   ctrl_clears_cnt_a: assert property (ctrl_write_s |=> counter_cleared_s) // [RL4]
      else $error("counter not cleared by control write");

   mode_field_a: assert property (ctrl_wr |=>
      mode == $past(pwdata_i[6:4])) // [RL1]
      else $error("mode field not taken from bits 6 to 4");

   off_release_a: assert property (((mode == MODE_OFF) | (mode == 3'h7)) |->
      output_a_oe_n_o & output_b_oe_n_o & (cnt_reg == 16'h0000)) // [RL7]
      else $error("pins not released in disabled mode");

   single_b_free_a: assert property ((mode == MODE_SINGLE) |->
      output_b_oe_n_o & !output_a_oe_n_o) // [RL21]
      else $error("single mode drove output b");

   hold_value_a: assert property ((!wrap & (mode != MODE_OFF) &
      (mode != 3'h7)) |=> $stable(val_a_reg) & $stable(val_b_reg)) // [RL6]
      else $error("value changed inside a running cycle");

   sequence twin16_wrap_s;
      (mode == MODE_TWIN16) & tick & (cnt_reg == 16'hffff) & !ctrl_wr;
   endsequence

   twin16_sync_a: assert property (twin16_wrap_s ##1
      ((mode == MODE_TWIN16) & (val_a_reg != 16'h0000) &
      (val_b_reg != 16'h0000)) |=> output_a_o & output_b_o) // [RL16]
      else $error("twin 16-bit outputs did not rise together");

   twin16_low_a: assert property (((mode == MODE_TWIN16) &
      (cnt_reg >= val_a_reg)) |=> !output_a_o) // [RL14]
      else $error("twin 16-bit output a high past its value");

   low_byte_hold_a: assert property ((wr & !is8 &
      (dopwm_sel(paddr_i) == 3'h2)) |=> (hid_a_reg == $past(pwdata_i[7:0]))
      & $stable(pend_a_reg)) // [RL5]
      else $error("low byte write reached the value directly");

   zero_reset_a: assert property ($rose(rstn_i) |-> ctrl_reg == CTRL_RST) // [RL22]
      else $error("control not zero after reset");
endmodule : dopwm_core

/* File: core/dopwm_pin_sync.sv */
// three-stage synchroniser with rising edge pulse for a clock-like pin
// assumes the pin toggles slower than half of sys_clk_i
`timescale 1ns/1ps
module dopwm_pin_sync
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic pin_i,
   output logic rise_o
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic lvl_reg;

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // level changes only when stages two and three agree
   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         lvl_reg <= 1'b0;
      else if (s2_reg == s3_reg)
         lvl_reg <= s3_reg;
   end

   assign rise_o = (s2_reg == s3_reg) & s3_reg & ~lvl_reg;
endmodule : dopwm_pin_sync

/* File: core/dopwm_pkg.sv */
// constants for the dual output pulse-width modulator
// assumes an apb slave at 32-bit data, one register per word, 25 MHz clock
// How it works
// RL1 - mode field bits 6:4 picks behaviour
// RL2 - prescale bits 3:2 divide 1/4/16/64
// RL3 - source bits 1:0: xtal/15, xtal, pin, pll
// RL4 - control write clears the counter
// RL5 - low byte held hidden, high write loads; 8-bit modes load the low byte directly
// RL6 - new value applies from next cycle
// RL7 - disabled mode releases both pins
// RL8 - single mode period from value_b
// RL9 - single mode high time from value_a
// RL10 - twin 8-bit period is value_b low plus one
// RL11 - twin 8-bit a falls at value_a low
// RL12 - twin 8-bit b rises b_high, falls a_high
// RL13 - twin 16-bit counter runs full 65536
// RL14 - twin 16-bit a high below value_a
// RL15 - twin 16-bit b high below value_b
// RL16 - twin 16-bit both rise at wrap
// RL17 - nrz sigma-delta, exact count per 65536
// RL18 - dual 8-bit, own period and duty
// RL19 - rz: high half clock then low
// RL20 - reserved mode acts as disabled
// RL21 - single mode drives only output a
// RL22 - control resets to zero
package dopwm_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] CTRL_IDX = 8'hae;
   localparam logic [7:0] VA_LO_IDX = 8'haf;
   localparam logic [7:0] VA_HI_IDX = 8'hb0;
   localparam logic [7:0] VB_LO_IDX = 8'hb1;
   localparam logic [7:0] VB_HI_IDX = 8'hb2;
   localparam logic [7:0] STAT_IDX = 8'hb3;
   localparam int ADDR_W = 10;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] VAL_RST = 16'h0000;
   localparam int MODE_LSB = 4;
   localparam int PRE_LSB = 2;
   localparam int SRC_LSB = 0;
   localparam logic [2:0] MODE_OFF = 3'h0;
   localparam logic [2:0] MODE_SINGLE = 3'h1;
   localparam logic [2:0] MODE_TWIN8 = 3'h2;
   localparam logic [2:0] MODE_TWIN16 = 3'h3;
   localparam logic [2:0] MODE_NRZ = 3'h4;
   localparam logic [2:0] MODE_DUAL8 = 3'h5;
   localparam logic [2:0] MODE_RZ = 3'h6;
   localparam logic [1:0] SRC_XTAL_DIV = 2'h0;
   localparam logic [1:0] SRC_XTAL = 2'h1;
   localparam logic [1:0] SRC_PIN = 2'h2;
   localparam logic [1:0] SRC_PLL = 2'h3;
   localparam int XTAL_DIV = 15;
   localparam logic [5:0] PRE_DIV1_M1 = 6'h00;
   localparam logic [5:0] PRE_DIV4_M1 = 6'h03;
   localparam logic [5:0] PRE_DIV16_M1 = 6'h0f;
   localparam logic [5:0] PRE_DIV64_M1 = 6'h3f;
   localparam int SYNC_PINS = 3;
endpackage : dopwm_pkg

/* File: core/dopwm_prescale.sv */
// source selection, crystal divider and counter prescaler
// assumes source edges arrive as one-cycle pulses on sys_clk_i
`timescale 1ns/1ps
module dopwm_prescale
   import dopwm_pkg::*;
#(
   parameter int XDIV = XTAL_DIV
)
(
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire logic clear_i,
   input wire logic [1:0] src_i,
   input wire logic [1:0] pre_i,
   input wire logic xtal_rise_i,
   input wire logic pin_rise_i,
   input wire logic pll_rise_i,
   output logic tick_o
);
   localparam logic [3:0] XDIV_M1 = 4'(XDIV - 1);
   logic [3:0] xdiv_reg;
   logic [5:0] pre_reg;
   logic [5:0] pre_top;
   logic src_tick;
   logic xdiv_tick;

   if (XDIV < 2 || XDIV > 16)
   begin : g_bad_div
      $error("crystal divider out of range");
   end

   assign xdiv_tick = xtal_rise_i & (xdiv_reg == XDIV_M1);

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         xdiv_reg <= 4'h0;
      else if (clear_i)
         xdiv_reg <= 4'h0;
      else if (xtal_rise_i)
         xdiv_reg <= xdiv_tick ? 4'h0 : xdiv_reg + 4'h1;
   end

   always_comb
   begin
      unique case (src_i) // [RL3]
         SRC_XTAL_DIV: src_tick = xdiv_tick;
         SRC_XTAL: src_tick = xtal_rise_i;
         SRC_PIN: src_tick = pin_rise_i;
         SRC_PLL: src_tick = pll_rise_i;
      endcase
      unique case (pre_i) // [RL2]
         2'h0: pre_top = PRE_DIV1_M1;
         2'h1: pre_top = PRE_DIV4_M1;
         2'h2: pre_top = PRE_DIV16_M1;
         2'h3: pre_top = PRE_DIV64_M1;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pre_reg <= 6'h00;
      else if (clear_i)
         pre_reg <= 6'h00;
      else if (src_tick)
         pre_reg <= (pre_reg >= pre_top) ? 6'h00 : pre_reg + 6'h01; // [RL2]
   end

   assign tick_o = src_tick & (pre_reg >= pre_top) & ~clear_i;

   tick_spacing_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      tick_o |=> !tick_o) // [RL2]
      else $error("prescaler ticked on two adjacent cycles");
endmodule : dopwm_prescale

/* File: verification/dopwm_load_model.sv */
// filter model on one modulator pin: integrates the time the pin is high
// assumes pin and its active-low enable are sampled on the system clock
`timescale 1ns/1ps
module dopwm_load_model
(
   input wire logic sys_clk_i,
   input wire logic clear_i,
   input wire logic pin_i,
   input wire logic oe_n_i,
   output int high_o
);
   // a released pin adds no charge to the filter
   always_ff @(posedge sys_clk_i)
   begin
      if (clear_i)
         high_o <= 0;
      else if (!oe_n_i && pin_i)
         high_o <= high_o + 1;
   end
endmodule : dopwm_load_model

/* File: verification/dual_output_pwm_unit_tb.sv */
// testbench for the dual output modulator: apb set-up and duty checks
// assumes pin clocks made on the system clock at fixed whole ratios
`timescale 1ns/1ps
module dual_output_pwm_unit_tb;
   import dopwm_pkg::*;
   logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, clr = 0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, perr, oa, oa_n, ob, ob_n;
   logic xtal = 0, pll = 0, ext = 0;
   int ha, hb, fail_count = 0, checked = 0;
   int tab[4] = '{150, 10, 7, 5};
   always #20 clk = ~clk;
   // pin clocks: crystal every 10, pll every 5, pin every 7 cycles
   int ph = 0;
   always @(posedge clk)
   begin
      ph <= (ph == 69) ? 0 : ph + 1;
      xtal <= (ph % 10) < 5;
      pll <= (ph % 5) < 2;
      ext <= (ph % 7) < 3;
   end
   dopwm_core dopwm_core_i (.sys_clk_i(clk), .rstn_i(rstn), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .xtal_clk_i(xtal), .pll_clk_i(pll), .external_count_clock_i(ext),
      .output_a_o(oa), .output_a_oe_n_o(oa_n), .output_b_o(ob),
      .output_b_oe_n_o(ob_n));
   dopwm_load_model dopwm_load_model_i (.sys_clk_i(clk), .clear_i(clr),
      .pin_i(oa), .oe_n_i(oa_n), .high_o(ha));
   dopwm_load_model dopwm_load_model_b_i (.sys_clk_i(clk), .clear_i(clr),
      .pin_i(ob), .oe_n_i(ob_n), .high_o(hb));

   task automatic apb(input logic w, input logic [7:0] idx,
      input logic [7:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   function automatic logic [7:0] ctl(input logic [2:0] m,
      input logic [1:0] p, input logic [1:0] s);
      return {1'b0, m, p, s};
   endfunction : ctl

   task automatic setup(input logic [7:0] c, input logic [15:0] va,
      input logic [15:0] vb);
      apb(1'b1, CTRL_IDX, 8'h00);
      apb(1'b1, VA_LO_IDX, va[7:0]);
      apb(1'b1, VA_HI_IDX, va[15:8]);
      apb(1'b1, VB_LO_IDX, vb[7:0]);
      apb(1'b1, VB_HI_IDX, vb[15:8]);
      apb(1'b1, CTRL_IDX, c);
   endtask : setup

   // settle one window, then integrate both pins over a whole window
   task automatic meas(input int win, input int ea, input int eb);
      repeat (win) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (win + 1) @(posedge clk);
      chk("high time a", ea, ha);
      chk("high time b", eb, hb);
   endtask : meas

   task automatic t_reset;
      apb(1'b0, CTRL_IDX, 8'h00);
      chk("control reset", 32'h0, rd);
      chk("mapped error", 1'b0, perr);
      chk("enable a reset", 1'b1, oa_n);
      chk("enable b reset", 1'b1, ob_n);
      apb(1'b0, 8'h10, 8'h00);
      chk("unmapped error", 1'b1, perr);
      chk("unmapped data", 32'h0, rd);
      for (int m = 0; m < 8; m++)
      begin
         apb(1'b1, CTRL_IDX, ctl(m[2:0], 2'h0, 2'h3));
         apb(1'b0, CTRL_IDX, 8'h00);
         chk("control readback", {25'h0, m[2:0], 4'h3}, rd);
         chk("enable a", m == 0 || m == 7, oa_n);
         chk("enable b", m == 0 || m == 1 || m == 7, ob_n);
      end
      $display("test reset and modes done");
   endtask : t_reset

   task automatic t_twin8;
      int t;
      for (int p = 0; p < 4; p++)
      begin
         setup(ctl(MODE_TWIN8, p[1:0], SRC_PLL), 16'h0703, 16'h0209);
         t = 5 * (4 ** p);
         meas(10 * t, 3 * t, 5 * t);
      end
      for (int s = 0; s < 4; s++)
      begin
         setup(ctl(MODE_TWIN8, 2'h0, s[1:0]), 16'h0703, 16'h0209);
         meas(10 * tab[s], 3 * tab[s], 5 * tab[s]);
      end
      $display("test twin 8-bit, prescale and source done");
   endtask : t_twin8

   task automatic t_single;
      setup(ctl(MODE_SINGLE, 2'h0, SRC_PLL), 16'h0005, 16'h0010);
      meas(160, 50, 0);
      apb(1'b1, CTRL_IDX, ctl(MODE_SINGLE, 2'h0, SRC_XTAL_DIV));
      apb(1'b1, VA_LO_IDX, 8'h08);
      apb(1'b0, STAT_IDX, 8'h00);
      chk("pending after low", 1'b0, rd[18]);
      apb(1'b1, VA_HI_IDX, 8'h00);
      apb(1'b0, STAT_IDX, 8'h00);
      chk("pending after high", 1'b1, rd[18]);
      apb(1'b0, VA_LO_IDX, 8'h00);
      chk("live value held", 32'h05, rd);
      repeat (2500) @(posedge clk);
      apb(1'b0, VA_LO_IDX, 8'h00);
      chk("live value at wrap", 32'h08, rd);
      $display("test single mode done");
   endtask : t_single

   task automatic t_twin16;
      setup(ctl(MODE_TWIN16, 2'h0, SRC_PLL), 16'h0003, 16'h0100);
      repeat (200) @(posedge clk);
      chk("output a past value", 1'b0, oa);
      chk("output b below value", 1'b1, ob);
      apb(1'b1, CTRL_IDX, ctl(MODE_TWIN16, 2'h0, SRC_XTAL_DIV));
      apb(1'b0, STAT_IDX, 8'h00);
      chk("counter cleared", 32'h0, {16'h0, rd[15:0]});
      chk("output a at zero", 1'b1, oa);
      chk("output b at zero", 1'b1, ob);
      $display("test twin 16-bit done");
   endtask : t_twin16

   task automatic t_other;
      setup(ctl(MODE_NRZ, 2'h0, SRC_PLL), 16'h4000, 16'hc000);
      meas(400, 100, 300);
      setup(ctl(MODE_RZ, 2'h1, SRC_PLL), 16'h4000, 16'hc000);
      meas(320, 40, 120);
      setup(ctl(MODE_DUAL8, 2'h0, SRC_PLL), 16'h0203, 16'h0409);
      meas(250, 75, 100);
      $display("test sigma-delta and dual 8-bit done");
   endtask : t_other

   task automatic stop_test;
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   initial
   begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset;
      t_twin8;
      t_single;
      t_twin16;
      t_other;
      stop_test;
   end

   initial
   begin
      repeat (40000) @(posedge clk);
      fail_count++;
      stop_test;
   end
endmodule : dual_output_pwm_unit_tb
